// ---- inc/cps_map.svh ----
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CPS_OFF_PWR_CTRL   8'h00
`define CPS_OFF_PWR_STAT   8'h04
`define CPS_OFF_ANA_CTRL   8'h08
`define CPS_OFF_GAIN       8'h0C
`define CPS_OFF_IMP        8'h10
`define CPS_OFF_UNSOL      8'h14
`define CPS_OFF_INT_STAT   8'h18
`define CPS_OFF_INT_MASK   8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CPS_PC_DEEP_SENSE  4
`define CPS_PC_DEEP_LINK   5
`define CPS_PC_DEEP_AGND   6
`define CPS_ANA_BEEP       0
`define CPS_ANA_MICREF     1
`define CPS_UNSOL_EN       4
`define CPS_INT_SENSE      0
`define CPS_INT_IMP        1
`define CPS_INT_WAKE       2
`define CPS_INT_BUSRST     3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CPS_RST_DEEP_CFG   3'h7
`define CPS_RST_ANA        2'h0
`define CPS_RST_CODE       8'h00
`define CPS_RST_TAG        4'h1
`define CPS_RST_UNSOL_EN   1'b1
`define CPS_RST_MASK       4'h0

// ----------------------------------------------------------------
// impedance return codes per bin
// ----------------------------------------------------------------
`define CPS_IMP_CODE_0     16'h0064
`define CPS_IMP_CODE_1     16'h012C
`define CPS_IMP_CODE_2     16'h028A
`define CPS_IMP_CODE_3     16'h03E8
`define CPS_IMP_CODE_4     16'h07D0
`define CPS_IMP_CODE_5     16'h0BB8
`define CPS_IMP_CODE_HI    16'h2710

// ----------------------------------------------------------------
// analog settings: gain steps in quarter dB, reference in tenths
// ----------------------------------------------------------------
`define CPS_PLAY_STEP_QDB  11'h003
`define CPS_REC_STEP_QDB   11'h006
`define CPS_MICREF_LO      4'h5
`define CPS_MICREF_HI      4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CPS_CLK_NS         8
`define CPS_BCLK_TMO_NS    400
`define CPS_BCLK_TMO_CYC   ((`CPS_BCLK_TMO_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_AGND_STEP_NS   1000
`define CPS_AGND_STEP_CYC  ((`CPS_AGND_STEP_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)

`endif

// ---- inc/cps_pkg.sv ----
package cps_pkg;

  // ----------------------------------------------------------------
  // power states, gray along d0-d1-d2-d3-deep
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ps_d0    = 3'h0,
    ps_d1    = 3'h1,
    ps_d2    = 3'h3,
    ps_d3def = 3'h2,
    ps_deep  = 3'h6
  } cps_pstate_e;

endpackage : cps_pkg

// ---- core/cps_sync.sv ----
`timescale 1ns/1ns
module cps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (en) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : cps_sync

// ---- core/cps_top.sv ----
// What this block does
// - impedance read returns code chosen by bin
// - bins 0,1,2 give 0064h, 012Ch, 028Ah
// - bins 3,4 give 03E8h, 07D0h
// - bin 5 gives 0BB8h, bins 6,7 give 2710h
// - converters only D0/D1; D2 keeps ports on
// - ground reference stays on without headphone amps
// - sense event: wake if link inactive (clock stopped or link unpowered), else unsolicited
// - link inactive once bit clock stopped for 400 ns
// - deep sleep without link exits only by reset
// - ground reference ramps one step at a time toward its target, never jumps
// - reset enters low power default state
// - beep path off during link reset
// - mic reference selects half or eight tenths
// - playback gain steps 0.75 dB per code
// - record gain steps 1.5 dB per code
// - unsolicited response tag in bits 31:28
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "cps_map.svh"
module cps_top (
  // clock, reset, enable
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // link pins
  input  wire logic        BITCLK_I,
  input  wire logic        LINK_RST_N_I,
  // sense and impedance circuits
  input  wire logic        SENSE_EVT_I,
  input  wire logic [2:0]  SENSE_PORT_I,
  input  wire logic        IMP_DONE_I,
  input  wire logic [2:0]  IMP_BIN_I,
  input  wire logic        BEEP_I,
  // power enables
  output logic             DAC_PWR_O,
  output logic             ADC_PWR_O,
  output logic             PORT_PWR_O,
  output logic             HP_AMP_PWR_O,
  output logic             MICREF_PWR_O,
  output logic             DIFF_AMP_PWR_O,
  output logic             SENSE_PWR_O,
  output logic             LINK_PWR_O,
  output logic             LINK_ACTIVE_O,
  output logic [7:0]       AGND_LEVEL_O,
  // events
  output logic             WAKE_O,
  output logic             UNSOL_VALID_O,
  output logic [31:0]      UNSOL_DATA_O,
  output logic             IRQ_O,
  // analog settings
  output logic             BEEP_O,
  output logic [3:0]       MICREF_TENTHS_O,
  output logic [10:0]      PLAY_ATTEN_QDB_O,
  output logic [10:0]      REC_GAIN_QDB_O
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] async_s;
  logic [5:0] data_s;

  cps_sync #(.W(5)) u_sync_ctl (
    .clk (CLK_I),
    .rst (RST_I),
    .en  (CE_I),
    .d   ({BEEP_I, IMP_DONE_I, SENSE_EVT_I, LINK_RST_N_I, BITCLK_I}),
    .q   (async_s)
  );

  cps_sync #(.W(6)) u_sync_dat (
    .clk (CLK_I),
    .rst (RST_I),
    .en  (CE_I),
    .d   ({SENSE_PORT_I, IMP_BIN_I}),
    .q   (data_s)
  );

  wire bclk_s     = async_s[0];
  wire link_rst_s = ~async_s[1];
  wire sense_s    = async_s[2];
  wire done_s     = async_s[3];
  wire beep_s     = async_s[4];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cps_pkg::cps_pstate_e pwr_state;
  cps_pkg::cps_pstate_e next_pwr_state;
  logic [2:0]  deep_cfg;
  logic [1:0]  ana_ctrl;
  logic [7:0]  play_code;
  logic [7:0]  rec_code;
  logic [2:0]  imp_bin;
  logic [3:0]  unsol_tag;
  logic        unsol_en;
  logic [3:0]  int_stat;
  logic [3:0]  int_mask;
  logic        wake_pend;
  logic [4:0]  prev_s;
  logic [6:0]  bclk_cnt;
  logic [6:0]  agnd_cnt;

  // ----------------------------------------------------------------
  // edge detection and bit clock watch
  // ----------------------------------------------------------------
  wire bclk_edge  = bclk_s & ~prev_s[0];
  wire bus_rst_ev = link_rst_s & prev_s[1];
  wire sense_rise = sense_s & ~prev_s[2];
  wire imp_rise   = done_s & ~prev_s[3];
  wire bclk_run   = bclk_cnt < 7'(`CPS_BCLK_TMO_CYC);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prev_s   <= 5'h00;
      bclk_cnt <= 7'(`CPS_BCLK_TMO_CYC);
    end else if (CE_I) begin
      prev_s   <= async_s;
      bclk_cnt <= bclk_edge ? 7'h00 : (bclk_run ? bclk_cnt + 7'h01 : bclk_cnt);
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_pc   = WR_I & (ADDR_I == `CPS_OFF_PWR_CTRL);
  wire wr_ana  = WR_I & (ADDR_I == `CPS_OFF_ANA_CTRL);
  wire wr_gain = WR_I & (ADDR_I == `CPS_OFF_GAIN);
  wire wr_uns  = WR_I & (ADDR_I == `CPS_OFF_UNSOL);
  wire wr_is   = WR_I & (ADDR_I == `CPS_OFF_INT_STAT);
  wire wr_im   = WR_I & (ADDR_I == `CPS_OFF_INT_MASK);

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  wire in_deep   = pwr_state == cps_pkg::ps_deep;
  wire deep_lock = in_deep & ~deep_cfg[`CPS_PC_DEEP_LINK - 4];

  always_comb begin
    next_pwr_state = pwr_state;
    if (bus_rst_ev) begin
      next_pwr_state = cps_pkg::ps_d3def;
    end else if (wr_pc & ~deep_lock) begin
      case (WDATA_I[2:0])
        3'h0:    next_pwr_state = cps_pkg::ps_d0;
        3'h1:    next_pwr_state = cps_pkg::ps_d1;
        3'h3:    next_pwr_state = cps_pkg::ps_d2;
        3'h2:    next_pwr_state = cps_pkg::ps_d3def;
        3'h6:    next_pwr_state = cps_pkg::ps_deep;
        default: next_pwr_state = pwr_state;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_state <= cps_pkg::ps_d3def;
      deep_cfg  <= `CPS_RST_DEEP_CFG;
    end else if (CE_I) begin
      pwr_state <= next_pwr_state;
      if (wr_pc & ~deep_lock) begin
        deep_cfg <= WDATA_I[`CPS_PC_DEEP_AGND:`CPS_PC_DEEP_SENSE];
      end
    end
  end

  // ----------------------------------------------------------------
  // power enables per state
  // ----------------------------------------------------------------
  wire full_on = (pwr_state == cps_pkg::ps_d0) | (pwr_state == cps_pkg::ps_d1);
  wire mid_on  = full_on | (pwr_state == cps_pkg::ps_d2);
  wire agnd_on = ~in_deep | deep_cfg[`CPS_PC_DEEP_AGND - 4];

  assign DAC_PWR_O      = full_on;
  assign ADC_PWR_O      = full_on;
  assign PORT_PWR_O     = mid_on;
  assign HP_AMP_PWR_O   = mid_on;
  assign MICREF_PWR_O   = mid_on;
  assign DIFF_AMP_PWR_O = mid_on;
  assign SENSE_PWR_O    = ~in_deep | deep_cfg[`CPS_PC_DEEP_SENSE - 4];
  assign LINK_PWR_O     = ~in_deep | deep_cfg[`CPS_PC_DEEP_LINK - 4];
  assign LINK_ACTIVE_O  = LINK_PWR_O & bclk_run;

  // ----------------------------------------------------------------
  // ground reference ramp
  // ----------------------------------------------------------------
  wire [7:0] agnd_tgt  = agnd_on ? 8'hFF : 8'h00;
  wire       agnd_tick = agnd_cnt == 7'(`CPS_AGND_STEP_CYC - 1);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      agnd_cnt     <= 7'h00;
      AGND_LEVEL_O <= 8'h00;
    end else if (CE_I) begin
      agnd_cnt <= agnd_tick ? 7'h00 : agnd_cnt + 7'h01;
      if (agnd_tick & (AGND_LEVEL_O < agnd_tgt)) begin
        AGND_LEVEL_O <= AGND_LEVEL_O + 8'h01;
      end else if (agnd_tick & (AGND_LEVEL_O > agnd_tgt)) begin
        AGND_LEVEL_O <= AGND_LEVEL_O - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // sense events, wake and unsolicited response
  // ----------------------------------------------------------------
  wire sense_ev  = sense_rise & SENSE_PWR_O;
  wire link_up   = LINK_PWR_O & bclk_run;
  wire wake_ev   = sense_ev & ~link_up;
  wire unsol_ev  = sense_ev & link_up & unsol_en;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_pend     <= 1'b0;
      UNSOL_VALID_O <= 1'b0;
      UNSOL_DATA_O  <= 32'h0000_0000;
    end else if (CE_I) begin
      wake_pend     <= wake_ev | (wake_pend & ~bclk_run);
      UNSOL_VALID_O <= unsol_ev;
      if (unsol_ev) begin
        UNSOL_DATA_O <= {unsol_tag, 25'h0000000, data_s[5:3]};
      end
    end
  end

  assign WAKE_O = wake_pend;

  // ----------------------------------------------------------------
  // impedance result
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      imp_bin <= 3'h0;
    end else if (CE_I & imp_rise) begin
      imp_bin <= data_s[2:0];
    end
  end

  wire [15:0] imp_code =
    (imp_bin == 3'h0) ? `CPS_IMP_CODE_0 :
    (imp_bin == 3'h1) ? `CPS_IMP_CODE_1 :
    (imp_bin == 3'h2) ? `CPS_IMP_CODE_2 :
    (imp_bin == 3'h3) ? `CPS_IMP_CODE_3 :
    (imp_bin == 3'h4) ? `CPS_IMP_CODE_4 :
    (imp_bin == 3'h5) ? `CPS_IMP_CODE_5 : `CPS_IMP_CODE_HI;

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ana_ctrl         <= `CPS_RST_ANA;
      play_code        <= `CPS_RST_CODE;
      rec_code         <= `CPS_RST_CODE;
      PLAY_ATTEN_QDB_O <= 11'h000;
      REC_GAIN_QDB_O   <= 11'h000;
      unsol_tag        <= `CPS_RST_TAG;
      unsol_en         <= `CPS_RST_UNSOL_EN;
      int_mask         <= `CPS_RST_MASK;
    end else if (CE_I) begin
      if (wr_ana) begin
        ana_ctrl <= WDATA_I[1:0];
      end
      if (wr_gain) begin
        play_code        <= WDATA_I[7:0];
        rec_code         <= WDATA_I[15:8];
        PLAY_ATTEN_QDB_O <= 11'(WDATA_I[7:0]) * `CPS_PLAY_STEP_QDB;
        REC_GAIN_QDB_O   <= 11'(WDATA_I[15:8]) * `CPS_REC_STEP_QDB;
      end
      if (wr_uns) begin
        unsol_tag <= WDATA_I[3:0];
        unsol_en  <= WDATA_I[`CPS_UNSOL_EN];
      end
      if (wr_im) begin
        int_mask <= WDATA_I[3:0];
      end
    end
  end

  assign MICREF_TENTHS_O = ana_ctrl[`CPS_ANA_MICREF] ? `CPS_MICREF_HI : `CPS_MICREF_LO;
  assign BEEP_O = beep_s & ana_ctrl[`CPS_ANA_BEEP] & ~link_rst_s;

  // ----------------------------------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------------------------------
  wire [3:0] int_set = {bus_rst_ev, wake_ev, imp_rise, sense_ev};
  wire [3:0] int_clr = wr_is ? WDATA_I[3:0] : 4'h0;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      int_stat <= 4'h0;
    end else if (CE_I) begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  assign IRQ_O = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    (ADDR_I == `CPS_OFF_PWR_CTRL) ? {25'h0, deep_cfg, 1'b0, pwr_state} :
    (ADDR_I == `CPS_OFF_PWR_STAT) ? {16'h0, AGND_LEVEL_O, 3'h0, LINK_ACTIVE_O,
                                     bclk_run, pwr_state} :
    (ADDR_I == `CPS_OFF_ANA_CTRL) ? {30'h0, ana_ctrl} :
    (ADDR_I == `CPS_OFF_GAIN)     ? {16'h0, rec_code, play_code} :
    (ADDR_I == `CPS_OFF_IMP)      ? {13'h0, imp_bin, imp_code} :
    (ADDR_I == `CPS_OFF_UNSOL)    ? {27'h0, unsol_en, unsol_tag} :
    (ADDR_I == `CPS_OFF_INT_STAT) ? {28'h0, int_stat} :
    (ADDR_I == `CPS_OFF_INT_MASK) ? {28'h0, int_mask} : 32'h0000_0000;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      RDATA_O <= RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  imp_low_a: assert property (CE_I && RD_I && ADDR_I == `CPS_OFF_IMP && imp_bin == 3'h2
    |=> RDATA_O[15:0] == 16'h028A) else $error("bin 2 code wrong");
  imp_mid_a: assert property (CE_I && RD_I && ADDR_I == `CPS_OFF_IMP && imp_bin == 3'h3
    |=> RDATA_O[15:0] == 16'h03E8) else $error("bin 3 code wrong");
  imp_high_a: assert property (CE_I && RD_I && ADDR_I == `CPS_OFF_IMP && imp_bin[2:1] == 2'h3
    |=> RDATA_O[15:0] == 16'h2710) else $error("bin 6/7 code wrong");
  conv_power_a: assert property (pwr_state == cps_pkg::ps_d2
    |-> !DAC_PWR_O && !ADC_PWR_O && PORT_PWR_O && HP_AMP_PWR_O) else $error("D2 enables wrong");
  agnd_hold_a: assert property (pwr_state == cps_pkg::ps_d3def
    |-> !HP_AMP_PWR_O && agnd_tgt == 8'hFF) else $error("ground ref dropped");
  sense_route_a: assert property (CE_I && sense_rise && SENSE_PWR_O
    |=> (WAKE_O ? !$past(link_up) : UNSOL_VALID_O == $past(unsol_en))) else $error("bad route");
  link_idle_a: assert property (!bclk_run |-> !LINK_ACTIVE_O) else $error("link active");
  deep_lock_a: assert property (CE_I && deep_lock && !bus_rst_ev
    |=> pwr_state == cps_pkg::ps_deep) else $error("left deep sleep");
  agnd_ramp_a: assert property ($changed(AGND_LEVEL_O)
    |-> (AGND_LEVEL_O - $past(AGND_LEVEL_O) == 8'h01) ||
        ($past(AGND_LEVEL_O) - AGND_LEVEL_O == 8'h01)) else $error("ground ref jumped");
  reset_state_a: assert property (disable iff (1'b0) RST_I
    |=> pwr_state == cps_pkg::ps_d3def) else $error("reset state wrong");
  beep_gate_a: assert property (link_rst_s |-> !BEEP_O) else $error("beep in reset");
  gain_step_a: assert property (PLAY_ATTEN_QDB_O == 11'(play_code) * 11'h003
    && REC_GAIN_QDB_O == 11'(rec_code) * 11'h006) else $error("gain step wrong");
  unsol_tag_a: assert property (UNSOL_VALID_O
    |-> UNSOL_DATA_O[31:28] == $past(unsol_tag)) else $error("tag wrong");
  imp_hold_a: assert property (CE_I && !imp_rise |=> $stable(imp_bin)) else $error("bin moved");

  wake_seen_c:  cover property (wake_ev);
  unsol_seen_c: cover property (UNSOL_VALID_O);
  deep_exit_c:  cover property (deep_lock ##1 pwr_state == cps_pkg::ps_d3def);
  agnd_full_c:  cover property (AGND_LEVEL_O == 8'hFF);

endmodule : cps_top

// ---- verification/cps_link_model.sv ----
`timescale 1ns/1ns
module cps_link_model (
  // controls
  input  wire logic run_i,
  input  wire logic rst_req_i,
  // link pins
  output logic      bitclk_o,
  output logic      link_rst_n_o
);
  // ----------------------------------------------------------------
  // bit clock, 80 ns, stands low while stopped
  // ----------------------------------------------------------------
  initial begin
    bitclk_o = 1'b0;
    #3;
    forever begin
      #40;
      bitclk_o = run_i ? ~bitclk_o : 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // bus reset only on request
  // ----------------------------------------------------------------
  assign link_rst_n_o = ~rst_req_i;
endmodule : cps_link_model

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, rst, wr, rd, run, lrst, sev, idone, beep;
  logic [7:0]  addr, a0;
  logic [31:0] wdata, rv;
  logic [2:0]  sport, ibin;
  wire         bclk, lrst_n, dac, adc, port, hp, mref, diff, spwr, lpwr, lact;
  wire         wake, uv, irq, beep_o;
  wire  [31:0] rdata, udata;
  wire  [7:0]  agnd;
  wire  [3:0]  tenths;
  wire  [10:0] play, rec;
  int          n_fail, num_checks, i;
  logic [15:0] codes [8] = '{16'h0064, 16'h012C, 16'h028A, 16'h03E8,
                             16'h07D0, 16'h0BB8, 16'h2710, 16'h2710};
  logic [2:0]  st [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
  logic [5:0]  pw [4] = '{6'h3F, 6'h3F, 6'h0F, 6'h00};

  cps_top cps_top_inst (
    .CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BITCLK_I(bclk), .LINK_RST_N_I(lrst_n),
    .SENSE_EVT_I(sev), .SENSE_PORT_I(sport), .IMP_DONE_I(idone), .IMP_BIN_I(ibin),
    .BEEP_I(beep), .DAC_PWR_O(dac), .ADC_PWR_O(adc), .PORT_PWR_O(port),
    .HP_AMP_PWR_O(hp), .MICREF_PWR_O(mref), .DIFF_AMP_PWR_O(diff),
    .SENSE_PWR_O(spwr), .LINK_PWR_O(lpwr), .LINK_ACTIVE_O(lact),
    .AGND_LEVEL_O(agnd), .WAKE_O(wake), .UNSOL_VALID_O(uv), .UNSOL_DATA_O(udata),
    .IRQ_O(irq), .BEEP_O(beep_o), .MICREF_TENTHS_O(tenths),
    .PLAY_ATTEN_QDB_O(play), .REC_GAIN_QDB_O(rec));

  cps_link_model cps_link_model_inst (
    .run_i(run), .rst_req_i(lrst), .bitclk_o(bclk), .link_rst_n_o(lrst_n));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wrr

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask : rdr

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, wr, rd, run, lrst, sev, idone, beep} = 8'h80;
    {addr, wdata, sport, ibin} = '0;
    n_fail = 0;
    num_checks = 0;
    cyc(20);
    rst <= 1'b0;
    rdr(8'h04);
    chk(rv[2:0], 3'h2);
    chk({spwr, lpwr, dac}, 3'h6);
    rdr(8'h14);
    chk(rv, 32'h11);
    rdr(8'h20);
    chk(rv, 32'h0);
    rdr(8'h18);
    chk(rv, 32'h0);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wrr(8'h00, {29'h0, st[i]});
      @(negedge clk);
      chk({dac, adc, port, hp, mref, diff}, pw[i]);
    end
    wrr(8'h0C, 32'h0403);
    wrr(8'h08, 32'h2);
    @(negedge clk);
    chk(play, 11'h009);
    chk(rec, 11'h018);
    chk(tenths, 4'h8);
    wrr(8'h08, 32'h0);
    @(negedge clk);
    chk(tenths, 4'h5);
    $display("test power and analog done");
    for (i = 0; i < 8; i++) begin
      cyc(1);
      ibin  <= i[2:0];
      cyc(4);
      idone <= 1'b1;
      cyc(6);
      idone <= 1'b0;
      rdr(8'h10);
      chk(rv, {13'h0, i[2:0], codes[i]});
    end
    cyc(1);
    ibin <= 3'h0;
    cyc(6);
    rdr(8'h10);
    chk(rv, {13'h0, 3'h7, 16'h2710});
    $display("test impedance done");
    wrr(8'h1C, 32'h1);
    wrr(8'h14, 32'h15);
    sport <= 3'h5;
    sev   <= 1'b1;
    cyc(4);
    sev   <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk({wake, lact, irq}, 3'h5);
    wrr(8'h18, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    cyc(1);
    run <= 1'b1;
    cyc(40);
    @(negedge clk);
    chk({wake, lact}, 2'h1);
    cyc(1);
    sev <= 1'b1;
    for (i = 0; i < 12 && uv !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(uv, 1'b1);
    chk(udata, {4'h5, 25'h0, 3'h5});
    cyc(1);
    sev <= 1'b0;
    #1;
    chk(uv, 1'b0);
    $display("test sense done");
    @(negedge clk);
    a0 = agnd;
    cyc(200);
    @(negedge clk);
    chk((agnd - a0 == 8'h1) || (agnd - a0 == 8'h2), 1'b1);
    chk({hp, agnd != 8'h0}, 2'h1);
    wrr(8'h08, 32'h1);
    beep <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(beep_o, 1'b1);
    wrr(8'h00, 32'h56);
    @(negedge clk);
    chk(lpwr, 1'b0);
    wrr(8'h00, 32'h0);
    rdr(8'h04);
    chk(rv[2:0], 3'h6);
    cyc(1);
    lrst <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(beep_o, 1'b0);
    rdr(8'h04);
    chk(rv[2:0], 3'h2);
    rdr(8'h18);
    chk(rv[3], 1'b1);
    cyc(1);
    lrst <= 1'b0;
    $display("test deep sleep done");
    stop_test();
  end
endmodule : tb
